// ==== src/startup_sequencer.sv ====
`timescale 1ns/10ps
`include "startup_params.svh"
// Startup sequencer, strap latch and status / enable pin logic
module startup_sequencer #(
  parameter int SYNTH_MAX_CYC = `SYNTH_MAX_CYC,
  parameter int JA_MAX_CYC    = `JA_MAX_CYC
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  // Pin levels (synchronous)
  input  wire logic                     status_pin_in,
  input  wire logic                     enable_chipsel_pin_in,
  input  wire logic                     sda_pin_in,
  input  wire logic                     scl_pin_in,
  // Configuration
  input  wire logic [3:0]               strap_decode_in,
  input  wire logic [6:0]               i2c_addr_prog_in,
  input  wire logic                     i2c_addr_prog_valid_in,
  input  wire logic [3:0]               status_sel_in,
  input  wire startup_pkg::pin_cfg_s    pin_cfg_in,
  input  wire logic                     ja_mode_in,
  // Commands and events
  input  wire logic                     cal_done_in,
  input  wire logic                     cfg_load_done_in,
  input  wire logic                     serial_active_in,
  input  wire logic                     ref_qualified_in,
  input  wire logic                     divider_sync_in,
  input  wire logic                     reinit_in,
  input  wire startup_pkg::status_src_s status_src_in,
  // Sequencer outputs
  output logic                          cal_start_out,
  output logic                          vco_gate_out,
  output logic                          div_reset_out,
  output logic                          ref_mon_en_out,
  output logic                          dpll_init_done_out,
  output logic                          drivers_controllable_out,
  output logic                          outputs_on_out,
  output logic                          startup_timeout_out,
  // Strap results
  output logic [2:0]                    strap_levels_latched_out,
  output logic [1:0]                    config_index_out,
  output logic [6:0]                    i2c_addr_out,
  // Status pin and enable pin pulls
  output logic                          status_pin_out,
  output logic                          status_pin_oe_out,
  output logic                          status_pin_pullup_out,
  output logic                          status_pin_pulldown_out,
  output logic                          enable_pin_pullup_out,
  output logic                          enable_pin_pulldown_out
);
  // Refuse counts the watchdog cannot serve
  if (SYNTH_MAX_CYC < 1 || JA_MAX_CYC < SYNTH_MAX_CYC) begin : g_bad_counts
    $error("startup_sequencer: bad timeout counts");
  end

  startup_pkg::seq_state_e state;
  startup_pkg::seq_state_e next_state;
  logic [2:0]  gate_cnt;
  logic [31:0] run_cnt;
  logic        strap_taken;
  logic [2:0]  straps;
  logic [1:0]  index_w;
  logic [6:0]  addr_w;
  logic        mux_level;

  // Ready means the config load has finished and the port is up
  wire dev_ready = cfg_load_done_in & serial_active_in; // R2
  wire lock_a    = status_src_in.apll_lock;
  wire lock_d    = status_src_in.dpll_lock;
  wire gate_end  = (gate_cnt == 3'(`GATE_CYC - 1));
  // Enable pin level after polarity, used as output gate
  wire oe_level  = enable_chipsel_pin_in ^ pin_cfg_in.enable_pol; // R7
  wire oe_ok     = ~pin_cfg_in.enable_gates | oe_level; // R6
  wire run_limit = ja_mode_in ? (run_cnt >= 32'(JA_MAX_CYC))
                              : (run_cnt >= 32'(SYNTH_MAX_CYC));
  wire [6:0] base_addr = i2c_addr_prog_valid_in ? i2c_addr_prog_in : `I2C_ADDR_RESET; // R23

  // Next state; reinit wins over sync request
  always_comb begin
    next_state = state;
    case (state)
      startup_pkg::ST_CAL:     if (cal_done_in) next_state = startup_pkg::ST_GATE;
      startup_pkg::ST_GATE:    if (gate_end) next_state = startup_pkg::ST_RELEASE; // R8
      startup_pkg::ST_RELEASE: if (gate_end) next_state = startup_pkg::ST_UNGATE;
      startup_pkg::ST_UNGATE:  next_state = startup_pkg::ST_ALOCK;
      startup_pkg::ST_ALOCK: begin
        if (lock_a) next_state = ja_mode_in ? startup_pkg::ST_QUAL
                                            : startup_pkg::ST_RUN; // R11
      end
      startup_pkg::ST_QUAL:    if (ref_qualified_in) next_state = startup_pkg::ST_DLOCK; // R12
      startup_pkg::ST_DLOCK:   if (lock_d) next_state = startup_pkg::ST_RUN;
      startup_pkg::ST_RUN:     next_state = startup_pkg::ST_RUN;
      default:                 next_state = startup_pkg::ST_CAL;
    endcase
    if (reinit_in) next_state = startup_pkg::ST_CAL; // R14 R24
    else if (divider_sync_in && state != startup_pkg::ST_CAL)
      next_state = startup_pkg::ST_GATE; // R13 R21
  end

  // State register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) state <= startup_pkg::ST_CAL;
    else state <= next_state;
  end

  // Gate and release phase counter, cleared on every state change
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) gate_cnt <= 3'h0;
    else if (next_state != state) gate_cnt <= 3'h0;
    else if (!gate_end) gate_cnt <= gate_cnt + 3'h1;
  end

  // Startup time watchdog; a flag only, sequence keeps waiting. Each pass is
  // timed from its own start, a stalled calibration counts, flag sticky to reinit.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run_cnt <= 32'h0;
      startup_timeout_out <= 1'b0;
    end else if (reinit_in) begin
      run_cnt <= 32'h0;
      startup_timeout_out <= run_limit && (state != startup_pkg::ST_RUN); // Set wins
    end else if (state == startup_pkg::ST_RUN) begin
      run_cnt <= 32'h0;
    end else begin
      run_cnt <= run_cnt + 32'h1;
      if (run_limit) startup_timeout_out <= 1'b1; // R22
    end
  end

  // Sequencer outputs. Dividers are held in reset under the gate and
  // all leave it together, so each rises on the first ungated edge.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cal_start_out            <= 1'b0;
      vco_gate_out             <= 1'b0;
      div_reset_out            <= 1'b1;
      ref_mon_en_out           <= 1'b0;
      dpll_init_done_out       <= 1'b0;
      drivers_controllable_out <= 1'b0;
      outputs_on_out           <= 1'b0;
    end else begin
      cal_start_out  <= (next_state == startup_pkg::ST_CAL);
      vco_gate_out   <= (next_state == startup_pkg::ST_GATE) ||
                        (next_state == startup_pkg::ST_RELEASE); // R8
      div_reset_out  <= (next_state == startup_pkg::ST_CAL) ||
                        (next_state == startup_pkg::ST_GATE); // R9 R19 R20
      ref_mon_en_out <= (next_state == startup_pkg::ST_QUAL) ||
                        (next_state == startup_pkg::ST_DLOCK) ||
                        (next_state == startup_pkg::ST_RUN && state != startup_pkg::ST_GATE); // R10
      dpll_init_done_out <= ja_mode_in && ((next_state == startup_pkg::ST_DLOCK) ||
                            (next_state == startup_pkg::ST_RUN)); // R12
      drivers_controllable_out <= (next_state == startup_pkg::ST_RUN);
      outputs_on_out <= (next_state == startup_pkg::ST_RUN) && oe_ok; // R6 R13 R14
    end
  end

  // Straps caught on the first clock after reset release
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_taken <= 1'b0;
      straps      <= 3'h0;
    end else begin
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        straps <= {sda_pin_in, enable_chipsel_pin_in, status_pin_in}; // R15
      end
    end
  end

  strap_decode u_decode (
    .code_in   (strap_decode_in),
    .straps_in (straps),
    .scl_in    (scl_pin_in),
    .addr_in   (base_addr),
    .index_out (index_w),
    .addr_out  (addr_w)
  );

  status_mux u_mux (
    .sel_in    (status_sel_in),
    .src_in    (status_src_in),
    .ready_in  (dev_ready),
    .level_out (mux_level)
  );

  // Strap results, registered
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_levels_latched_out <= 3'h0;
      config_index_out         <= 2'h0;
      i2c_addr_out             <= `I2C_ADDR_RESET;
    end else if (strap_taken) begin
      strap_levels_latched_out <= straps;
      config_index_out         <= index_w; // R16
      i2c_addr_out             <= addr_w; // R18
    end
  end

  // Status pin driver; held off before config load so the strap reads clean
  wire pin_val = mux_level ^ pin_cfg_in.status_pol; // R3
  wire pin_oe  = cfg_load_done_in & ~pin_cfg_in.status_hiz &
                 (~pin_cfg_in.status_pin_open_drain | ~pin_val); // R4 R5
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_pin_out          <= 1'b0;
      status_pin_oe_out       <= 1'b0;
      status_pin_pullup_out   <= 1'b0;
      status_pin_pulldown_out <= 1'b0;
      enable_pin_pullup_out   <= 1'b0;
      enable_pin_pulldown_out <= 1'b0;
    end else begin
      status_pin_out          <= pin_cfg_in.status_pin_open_drain ? 1'b0 : pin_val;
      status_pin_oe_out       <= pin_oe; // R4 R5
      status_pin_pullup_out   <= pin_cfg_in.status_pin_pullup_en; // R3
      status_pin_pulldown_out <= pin_cfg_in.status_pin_pulldown_en;
      enable_pin_pullup_out   <= pin_cfg_in.enable_pin_pullup_en; // R7
      enable_pin_pulldown_out <= pin_cfg_in.enable_pin_pulldown_en;
    end
  end

  // Checks
  property p_oe_before_load;
    @(posedge clk_in) disable iff (sys_rst_in)
      !$past(cfg_load_done_in) |-> !status_pin_oe_out;
  endproperty
  a_oe_before_load: assert property (p_oe_before_load) else $error("status pin driven early"); // R5

  property p_od_low;
    @(posedge clk_in) disable iff (sys_rst_in)
      status_pin_oe_out && $past(pin_cfg_in.status_pin_open_drain) |-> !status_pin_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high"); // R4

  property p_reinit_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      reinit_in |=> !outputs_on_out && cal_start_out;
  endproperty
  a_reinit_off: assert property (p_reinit_off) else $error("reinit kept outputs"); // R14

  property p_sync_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      divider_sync_in && !reinit_in && state != startup_pkg::ST_CAL
        |=> !outputs_on_out && vco_gate_out;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync kept outputs"); // R13

  property p_gate_seq;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(vco_gate_out) && !reinit_in && !divider_sync_in |-> div_reset_out
        ##4 (!div_reset_out && vco_gate_out);
  endproperty
  a_gate_seq: assert property (p_gate_seq) else $error("divider release order"); // R8

  property p_mon_after_lock;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(ref_mon_en_out) |-> $past(lock_a);
  endproperty
  a_mon_after_lock: assert property (p_mon_after_lock) else $error("monitor before lock"); // R10

  property p_ja_dlock;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(drivers_controllable_out) && $past(ja_mode_in) |-> $past(lock_d);
  endproperty
  a_ja_dlock: assert property (p_ja_dlock) else $error("jitter mode without dlock"); // R12

  property p_strap_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      strap_taken && $past(strap_taken) |-> $stable(straps);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed"); // R15

  property p_ready_src;
    @(posedge clk_in) disable iff (sys_rst_in)
      status_sel_in == `SEL_DEV_READY && !dev_ready |-> mux_level == 1'b0;
  endproperty
  a_ready_src: assert property (p_ready_src) else $error("ready without load"); // R2

  c_run:    cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(outputs_on_out));
  c_ja:     cover property (@(posedge clk_in) disable iff (sys_rst_in)
                            ja_mode_in && $rose(dpll_init_done_out));
  c_resync: cover property (@(posedge clk_in) disable iff (sys_rst_in)
                            state == startup_pkg::ST_RUN && divider_sync_in);
endmodule : startup_sequencer

// ==== src/startup_params.svh ====
`ifndef STARTUP_PARAMS_SVH
`define STARTUP_PARAMS_SVH
// How it works
// [R1] Status pin shows one selected source
// [R2] Ready source needs config load and port
// [R3] Polarity inverts status; pull bits pass out
// [R4] Tristate floats pin; open drain drives low
// [R5] Status driver off until config load done
// [R6] Enable input gates outputs once controllable
// [R7] Enable input has polarity and pull bits
// [R8] Gate clock, release dividers, ungate clock
// [R9] Dividers rise on first ungated cycle
// [R10] Monitors enabled only after analog lock
// [R11] Synth mode: outputs on after analog lock
// [R12] Jitter mode: init done, digital lock, outputs
// [R13] Sync trigger reruns sync, outputs off
// [R14] Reinit restarts from calibration, outputs off
// [R15] Strap levels latched at reset release
// [R16] Two-bit index selects user configuration
// [R17] Decode codes map pins to index
// [R18] Decode picks address bits from pin
// [R19] Output dividers synchronised together
// [R20] Feedback dividers synchronised for phase
// [R21] Crystal reference sync still relocks loops
// [R22] Startup bounded: 10 ms synth, 1 s jitter
// [R23] Address defaults to 0x09
// [R24] Sequencer is a state machine

// Status source select codes
`define SEL_APLL_LOCK   4'h0
`define SEL_DPLL_LOCK   4'h1
`define SEL_REF0_LOS    4'h2
`define SEL_REF1_LOS    4'h3
`define SEL_XO_LOS      4'h4
`define SEL_REF0_ACT    4'h5
`define SEL_REF1_ACT    4'h6
`define SEL_REF0_INV    4'h7
`define SEL_REF1_INV    4'h8
`define SEL_DEV_INT     4'h9
`define SEL_DEV_READY   4'hA
`define SEL_LOW         4'hB
`define SEL_HIGH        4'hC
// Strap field bit positions, default decode code and reset address
`define STRAP_STATUS    0
`define STRAP_ENABLE    1
`define STRAP_SDA       2
`define DECODE_DEFAULT  4'h4
`define I2C_ADDR_RESET  7'h09
// Timing
`define CLK_MHZ         25
`define APLL_LOCK_US    200
`define SYNTH_MAX_MS    10
`define JA_MAX_MS       1000
`define SYNTH_MAX_CYC   (`SYNTH_MAX_MS * 1000 * `CLK_MHZ)
`define JA_MAX_CYC      (`JA_MAX_MS * 1000 * `CLK_MHZ)
`define GATE_CYC        4
`endif

// ==== src/startup_pkg.sv ====
package startup_pkg;
  typedef enum logic [2:0] {
    ST_CAL     = 3'b000,
    ST_GATE    = 3'b001,
    ST_RELEASE = 3'b010,
    ST_UNGATE  = 3'b011,
    ST_ALOCK   = 3'b100,
    ST_QUAL    = 3'b101,
    ST_DLOCK   = 3'b110,
    ST_RUN     = 3'b111
  } seq_state_e;

  typedef struct packed {
    logic apll_lock;
    logic dpll_lock;
    logic ref0_los;
    logic ref1_los;
    logic xo_los;
    logic ref0_act;
    logic ref1_act;
    logic ref0_inv;
    logic ref1_inv;
    logic dev_int;
  } status_src_s;

  typedef struct packed {
    logic status_pin_pullup_en;
    logic status_pin_pulldown_en;
    logic status_pin_open_drain;
    logic status_hiz;
    logic status_pol;
    logic enable_pin_pullup_en;
    logic enable_pin_pulldown_en;
    logic enable_pol;
    logic enable_gates;
  } pin_cfg_s;
endpackage : startup_pkg

// ==== src/strap_decode.sv ====
`timescale 1ns/10ps
`include "startup_params.svh"
// Pure decode of latched straps into configuration index and address
module strap_decode (
  // Inputs
  input  wire logic [3:0] code_in,
  input  wire logic [2:0] straps_in,
  input  wire logic       scl_in,
  input  wire logic [6:0] addr_in,
  // Outputs
  output logic      [1:0] index_out,
  output logic      [6:0] addr_out
);
  wire s_st = straps_in[`STRAP_STATUS];
  wire s_en = straps_in[`STRAP_ENABLE];
  wire s_sd = straps_in[`STRAP_SDA];

  // Index and address low bits per decode code; reserved codes give index 0
  always_comb begin
    index_out = 2'h0;
    addr_out  = addr_in;
    case (code_in)
      4'h0: index_out = 2'h0; // R16 R17
      4'h1: index_out = 2'h1;
      4'h2: index_out = 2'h2;
      4'h3: index_out = 2'h3;
      4'h4: index_out = {s_en, s_st};
      4'h5: begin
        index_out   = {s_sd, s_st};
        addr_out[0] = s_en; // R18
      end
      4'h6: begin
        index_out   = {s_sd, s_en};
        addr_out[0] = s_st;
      end
      4'h7: index_out = {s_sd, scl_in};
      4'h8: begin
        index_out = {1'b0, s_st};
        addr_out[1:0] = {s_sd, s_en};
      end
      4'h9: begin
        index_out = {1'b0, s_en};
        addr_out[1:0] = {s_sd, s_st};
      end
      default: index_out = 2'h0;
    endcase
  end
endmodule : strap_decode

// ==== src/status_mux.sv ====
`timescale 1ns/10ps
`include "startup_params.svh"
// Status source select
module status_mux (
  // Inputs
  input  wire logic [3:0]               sel_in,
  input  wire startup_pkg::status_src_s src_in,
  input  wire logic                     ready_in,
  // Outputs
  output logic                          level_out
);
  always_comb begin
    case (sel_in)
      `SEL_APLL_LOCK: level_out = src_in.apll_lock; // R1
      `SEL_DPLL_LOCK: level_out = src_in.dpll_lock;
      `SEL_REF0_LOS:  level_out = src_in.ref0_los;
      `SEL_REF1_LOS:  level_out = src_in.ref1_los;
      `SEL_XO_LOS:    level_out = src_in.xo_los;
      `SEL_REF0_ACT:  level_out = src_in.ref0_act;
      `SEL_REF1_ACT:  level_out = src_in.ref1_act;
      `SEL_REF0_INV:  level_out = src_in.ref0_inv;
      `SEL_REF1_INV:  level_out = src_in.ref1_inv;
      `SEL_DEV_INT:   level_out = src_in.dev_int;
      `SEL_DEV_READY: level_out = ready_in;
      `SEL_HIGH:      level_out = 1'b1;
      default:        level_out = 1'b0;
    endcase
  end
endmodule : status_mux

// ==== sim/board_model.sv ====
`timescale 1ns/10ps
// Board straps, PLL loops and calibration engine as seen by the sequencer
module board_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Board controls
  input  wire logic strap_status_in,
  input  wire logic stall_in,
  // From the device
  input  wire logic status_drive_in,
  input  wire logic status_oe_in,
  input  wire logic status_pu_in,
  input  wire logic status_pd_in,
  input  wire logic cal_start_in,
  input  wire logic vco_gate_in,
  input  wire logic init_done_in,
  // To the device
  output logic      status_wire_out,
  output logic      cal_done_out,
  output logic      apll_lock_out,
  output logic      dpll_lock_out
);
  logic [3:0] lock_cnt;

  // Pin level: driver first, then internal pulls, else the board strap resistor
  assign status_wire_out = status_oe_in ? status_drive_in :
                           status_pu_in ? 1'b1 : status_pd_in ? 1'b0 : strap_status_in;
  // Stall holds off calibration and lock, standing in for a slow loop
  assign apll_lock_out = (lock_cnt == 4'hA) && !stall_in;

  // Lock is lost whenever the VCO clock is gated, so every sync forces a relock
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lock_cnt      <= 4'h0;
      cal_done_out  <= 1'b0;
      dpll_lock_out <= 1'b0;
    end else begin
      lock_cnt      <= (vco_gate_in || cal_start_in) ? 4'h0 :
                       lock_cnt + {3'h0, lock_cnt != 4'hA};
      cal_done_out  <= cal_start_in && !stall_in;
      dpll_lock_out <= init_done_in && apll_lock_out;
    end
  end
endmodule : board_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam int SYN_CYC = 50;
  localparam int K_CAL = 0, K_VCO = 1, K_DIV = 2, K_MON = 3, K_INIT = 4, K_CTRL = 5;
  localparam int K_ON = 6, K_TMO = 7, K_STRAP = 8, K_IDX = 9, K_ADDR = 10, K_PIN = 11;
  localparam int K_OE = 12, K_PULL = 13;
  typedef struct {int due; int kind; logic [7:0] val;} note_s;

  logic                     clk_in, sys_rst_in, en_pin, sda, scl, strap_st, stall, prog_v;
  logic                     ja, load_done, ser_act, ref_q, dsync, reinit;
  logic [3:0]               code, sel;
  logic [6:0]               prog, addr;
  logic [7:0]               rbits, flags;
  logic [31:0]              rs;
  startup_pkg::pin_cfg_s    cfg;
  startup_pkg::status_src_s src;
  logic                     st_wire, cal_done, apll, dpll, cal, vco, divr, mon, init, ctrl;
  logic                     on, tmo, st_out, st_oe, st_pu, st_pd, en_pu, en_pd;
  logic [2:0]               straps;
  logic [1:0]               idx;
  int                       cyc, fails, check_count;
  note_s                    notes[$];

  // Loop states come from the board model, the rest of the sources are random
  assign src   = {apll, dpll, rbits};
  assign flags = {tmo, on, ctrl, init, mon, divr, vco, cal};

  startup_sequencer #(.SYNTH_MAX_CYC(SYN_CYC), .JA_MAX_CYC(100)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .status_pin_in(st_wire),
    .enable_chipsel_pin_in(en_pin), .sda_pin_in(sda), .scl_pin_in(scl),
    .strap_decode_in(code), .i2c_addr_prog_in(prog), .i2c_addr_prog_valid_in(prog_v),
    .status_sel_in(sel), .pin_cfg_in(cfg), .ja_mode_in(ja), .cal_done_in(cal_done),
    .cfg_load_done_in(load_done), .serial_active_in(ser_act), .ref_qualified_in(ref_q),
    .divider_sync_in(dsync), .reinit_in(reinit), .status_src_in(src),
    .cal_start_out(cal), .vco_gate_out(vco), .div_reset_out(divr), .ref_mon_en_out(mon),
    .dpll_init_done_out(init), .drivers_controllable_out(ctrl), .outputs_on_out(on),
    .startup_timeout_out(tmo), .strap_levels_latched_out(straps),
    .config_index_out(idx), .i2c_addr_out(addr), .status_pin_out(st_out),
    .status_pin_oe_out(st_oe), .status_pin_pullup_out(st_pu),
    .status_pin_pulldown_out(st_pd), .enable_pin_pullup_out(en_pu),
    .enable_pin_pulldown_out(en_pd));

  board_model board_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .strap_status_in(strap_st), .stall_in(stall),
    .status_drive_in(st_out), .status_oe_in(st_oe), .status_pu_in(st_pu),
    .status_pd_in(st_pd), .cal_start_in(cal), .vco_gate_in(vco), .init_done_in(init),
    .status_wire_out(st_wire), .cal_done_out(cal_done), .apll_lock_out(apll),
    .dpll_lock_out(dpll));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] obs(input int k);
    case (k)
      K_STRAP: return {5'h0, straps};
      K_IDX:   return {6'h0, idx};
      K_ADDR:  return {1'h0, addr};
      K_PIN:   return {7'h0, st_out};
      K_OE:    return {7'h0, st_oe};
      K_PULL:  return {4'h0, st_pu, st_pd, en_pu, en_pd};
      default: return {7'h0, flags[k[2:0]]};
    endcase
  endfunction : obs

  // Straps are {data, enable, status}
  function automatic logic [1:0] exp_idx(input logic [3:0] c, input logic [2:0] s,
                                         input logic sc);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return c[1:0];
      4'h4: return s[1:0];
      4'h5: return {s[2], s[0]};
      4'h6: return s[2:1];
      4'h7: return {s[2], sc};
      4'h8: return {1'b0, s[0]};
      4'h9: return {1'b0, s[1]};
      default: return 2'h0;
    endcase
  endfunction : exp_idx

  function automatic logic [6:0] exp_addr(input logic [3:0] c, input logic [2:0] s,
                                          input logic [6:0] b);
    exp_addr = b;
    case (c)
      4'h5: exp_addr[0] = s[1];
      4'h6: exp_addr[0] = s[0];
      4'h8: exp_addr[1:0] = s[2:1];
      4'h9: exp_addr[1:0] = {s[2], s[0]};
      default: ;
    endcase
  endfunction : exp_addr

  function automatic logic exp_status(input logic [3:0] s, input logic [9:0] v,
                                      input logic rdy);
    if (s < 4'hA) return v[4'h9 - s];
    return (s == 4'hA) ? rdy : (s == 4'hC);
  endfunction : exp_status

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask : step

  // Called at a rising edge: checked d cycles after that edge, so d = 1 is the edge at which the design sees the new inputs
  task automatic expect_in(input int d, input int k, input logic [7:0] v);
    notes.push_back('{cyc + 1 + d, k, v});
  endtask : expect_in

  task automatic compare(input int k, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t result %0d got %h expected %h", $time, k, got, exp);
    end
  endtask : compare

  task automatic wait_for(input int k, input logic [7:0] v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (obs(k) !== v && n < lim);
    compare(k, obs(k), v);
  endtask : wait_for

  task automatic end_test(input string name);
    step(2);
    $display("test %s finished", name);
  endtask : end_test

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) cyc <= cyc + 1;

  // Results are judged at the falling edge, clear of the launching edge
  always @(negedge clk_in) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      compare(notes[0].kind, obs(notes[0].kind), notes[0].val);
      void'(notes.pop_front());
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 3000);
    fails++;
    test_done();
  end

  // Stimulus
  initial begin
    logic v;
    {sys_rst_in, strap_st, sda, stall} = 4'hF;
    {en_pin, scl, prog_v, ja, load_done, ser_act, ref_q, dsync, reinit} = 9'h000;
    {code, sel, prog, rbits} = {4'h4, 4'hC, 7'h00, 8'h00};
    cfg = '0;
    rs = 32'h4;
    {cyc, fails, check_count} = 0;
    step(12);
    compare(K_DIV, obs(K_DIV), 8'h01);
    compare(K_ADDR, obs(K_ADDR), 8'h09);
    sys_rst_in <= 1'b0;
    expect_in(2, K_STRAP, 8'h05);
    expect_in(1, K_CAL, 8'h01);
    expect_in(2, K_IDX, 8'h01);
    step(1);
    sda <= 1'b0;
    for (int c = 0; c < 11; c++) begin
      step(1);
      rs = xs(rs);
      code <= c[3:0];
      {prog, prog_v, scl} <= rs[8:0];
      expect_in(1, K_IDX, {6'h0, exp_idx(c[3:0], 3'h5, rs[0])});
      expect_in(1, K_ADDR, {1'h0, exp_addr(c[3:0], 3'h5, rs[1] ? rs[8:2] : 7'h09)});
    end
    end_test("straps");
    code <= 4'h4;
    stall <= 1'b0;
    wait_for(K_VCO, 8'h01, 20);
    expect_in(2, K_DIV, 8'h01);
    expect_in(3, K_DIV, 8'h00);
    expect_in(6, K_VCO, 8'h01);
    expect_in(7, K_VCO, 8'h00);
    expect_in(7, K_MON, 8'h00);
    wait_for(K_CTRL, 8'h01, 40);
    compare(K_MON, obs(K_MON), 8'h01);
    compare(K_ON, obs(K_ON), 8'h01);
    end_test("startup");
    for (int i = 0; i < 4; i++) begin
      step(1);
      rs = xs(rs);
      {cfg.enable_gates, cfg.enable_pol, en_pin} <= {1'b1, i[1:0]};
      {cfg.enable_pin_pullup_en, cfg.enable_pin_pulldown_en} <= rs[1:0];
      expect_in(1, K_ON, {7'h0, i[0] ^ i[1]});
      expect_in(1, K_PULL, {6'h0, rs[1:0]});
    end
    step(1);
    cfg <= '0;
    expect_in(1, K_OE, 8'h00);
    end_test("enable");
    load_done <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      step(1);
      rs = xs(rs);
      {sel, rbits, ser_act} <= {i[3:0], rs[8:0]};
      {cfg.status_pin_pullup_en, cfg.status_pin_pulldown_en} <= rs[13:12];
      {cfg.status_pin_open_drain, cfg.status_pol} <= {rs[11], rs[9]};
      cfg.status_hiz <= rs[10] & rs[14];
      v = exp_status(i[3:0], {apll, dpll, rs[8:1]}, rs[0]) ^ rs[9];
      expect_in(1, K_OE, {7'h0, !(rs[10] & rs[14]) & (!rs[11] | !v)});
      expect_in(1, K_PULL, {4'h0, rs[13:12], 2'h0});
      if (!(rs[10] & rs[14]) & (!rs[11] | !v)) expect_in(1, K_PIN, {7'h0, v});
    end
    end_test("status");
    dsync <= 1'b1;
    expect_in(1, K_ON, 8'h00);
    expect_in(1, K_VCO, 8'h01);
    step(1);
    dsync <= 1'b0;
    wait_for(K_ON, 8'h01, 60);
    end_test("sync");
    {stall, reinit} <= 2'h3;
    expect_in(1, K_CAL, 8'h01);
    expect_in(1, K_ON, 8'h00);
    step(1);
    reinit <= 1'b0;
    step(SYN_CYC + 10);
    @(negedge clk_in);
    compare(K_TMO, obs(K_TMO), 8'h01);
    compare(K_CAL, obs(K_CAL), 8'h01);
    step(1);
    stall <= 1'b0;
    wait_for(K_ON, 8'h01, 60);
    compare(K_TMO, obs(K_TMO), 8'h01);
    end_test("reinit");
    {ja, reinit} <= 2'h3;
    step(1);
    reinit <= 1'b0;
    wait_for(K_MON, 8'h01, 60);
    step(10);
    @(negedge clk_in);
    compare(K_INIT, obs(K_INIT), 8'h00);
    compare(K_ON, obs(K_ON), 8'h00);
    compare(K_TMO, obs(K_TMO), 8'h00);
    step(1);
    ref_q <= 1'b1;
    expect_in(1, K_INIT, 8'h01);
    wait_for(K_ON, 8'h01, 20);
    end_test("jitter");
    step(3);
    test_done();
  end
endmodule : tb_top
